// ### common/phc_bus_if.sv
`timescale 1ns/1ns
interface phc_bus_if;
  // Device drive, enables high while driving
  logic        d_frame_n, d_irdy_n, d_mst_oe;
  logic        d_trdy_n, d_stop_n, d_devsel_n, d_tgt_oe;
  logic [3:0]  d_cbe_n;
  logic [31:0] d_ad, d_tad;
  logic        d_ad_oe, d_tad_oe, d_req_n, d_req_oe;
  // Host drive
  logic        h_frame_n, h_irdy_n, h_mst_oe;
  logic        h_trdy_n, h_stop_n, h_devsel_n, h_tgt_oe;
  logic [3:0]  h_cbe_n;
  logic [31:0] h_ad, h_tad;
  logic        h_ad_oe, h_tad_oe;
  logic        gnt_n, idsel, rst_n;
  // Resolved lines, pulled up when undriven, except ad which reads zero
  logic        frame_n, irdy_n, trdy_n, stop_n, devsel_n, req_n;
  logic [3:0]  cbe_n;
  logic [31:0] ad;

  function automatic logic pu(input logic oe, input logic v);
    return oe ? v : 1'b1;
  endfunction

  assign frame_n  = pu(d_mst_oe, d_frame_n) & pu(h_mst_oe, h_frame_n);
  assign irdy_n   = pu(d_mst_oe, d_irdy_n) & pu(h_mst_oe, h_irdy_n);
  assign trdy_n   = pu(d_tgt_oe, d_trdy_n) & pu(h_tgt_oe, h_trdy_n);
  assign stop_n   = pu(d_tgt_oe, d_stop_n) & pu(h_tgt_oe, h_stop_n);
  assign devsel_n = pu(d_tgt_oe, d_devsel_n) & pu(h_tgt_oe, h_devsel_n);
  assign req_n    = pu(d_req_oe, d_req_n);
  assign cbe_n    = d_mst_oe ? d_cbe_n : (h_mst_oe ? h_cbe_n : phc_pkg::CBE_IDLE_N);
  assign ad       = d_ad_oe ? d_ad : d_tad_oe ? d_tad : h_ad_oe ? h_ad :
                    h_tad_oe ? h_tad : phc_pkg::AD_ZERO;

  modport dev (
    output d_frame_n, d_irdy_n, d_mst_oe, d_trdy_n, d_stop_n, d_devsel_n, d_tgt_oe,
    output d_cbe_n, d_ad, d_tad, d_ad_oe, d_tad_oe, d_req_n, d_req_oe,
    input  frame_n, irdy_n, trdy_n, stop_n, devsel_n, cbe_n, ad, gnt_n, idsel, rst_n
  );
  modport host (
    output h_frame_n, h_irdy_n, h_mst_oe, h_trdy_n, h_stop_n, h_devsel_n, h_tgt_oe,
    output h_cbe_n, h_ad, h_tad, h_ad_oe, h_tad_oe, gnt_n, idsel, rst_n,
    input  frame_n, irdy_n, trdy_n, stop_n, devsel_n, cbe_n, ad, req_n
  );
endinterface

// ### common/phc_pkg.sv
package phc_pkg;
  localparam int          CLK_HZ              = 10_000_000;
  localparam int          DEVSEL_TIMEOUT_CLKS = 5;
  localparam int          DECODE_CLKS         = 2;
  localparam int          RST_MIN_CLKS        = 10;
  localparam logic [2:0]  CMD_CFG_HI          = 3'h5;
  localparam logic [2:0]  CMD_MEM_HI          = 3'h3;
  localparam logic [3:0]  BE_ALL_N            = 4'h0;
  localparam logic [3:0]  CBE_IDLE_N          = 4'hF;
  localparam logic [31:0] AD_ZERO             = 32'h0000_0000;
  localparam logic [31:0] ADDR_STEP           = 32'h0000_0004;

  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_REQ  = 5'h02,
    M_ADDR = 5'h04,
    M_DATA = 5'h08,
    M_TURN = 5'h10
  } phc_mst_state_t;

  typedef enum logic [3:0] {
    T_IDLE = 4'h1,
    T_DEC  = 4'h2,
    T_DATA = 4'h4,
    T_TURN = 4'h8
  } phc_tgt_state_t;

  function automatic logic cmd_is_cfg(input logic [3:0] c);
    return c[3:1] == CMD_CFG_HI;
  endfunction

  function automatic logic cmd_is_mem(input logic [3:0] c);
    return c[3:1] == CMD_MEM_HI;
  endfunction

  function automatic logic cmd_is_write(input logic [3:0] c);
    return c[0];
  endfunction
endpackage

// ### design/phc_device.sv
`timescale 1ns/1ns
module phc_device #(
  parameter logic [31:0] BAR_BASE = 32'h0000_0000,
  parameter logic [31:0] BAR_MASK = 32'hFFFF_F000,
  parameter int          LEN_W    = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Bus end
  phc_bus_if.dev                bus,
  // Master request side
  input  wire logic             mst_start,
  input  wire logic [31:0]      mst_addr,
  input  wire logic [3:0]       mst_cmd,
  input  wire logic [LEN_W-1:0] mst_len,
  input  wire logic             mst_ready,
  input  wire logic [31:0]      mst_wdata,
  output logic                  mst_busy,
  output logic                  mst_take,
  output logic                  mst_xfer,
  output logic [31:0]           mst_rdata,
  output logic                  mst_done,
  output logic                  mst_abort,
  output logic                  mst_stopped,
  // Target side
  input  wire logic             tgt_ready,
  input  wire logic             tgt_stop,
  input  wire logic [31:0]      tgt_rdata,
  output logic                  tgt_sel,
  output logic                  tgt_cfg,
  output logic                  tgt_write,
  output logic [31:0]           tgt_addr,
  output logic                  tgt_take,
  output logic                  tgt_xfer,
  output logic [31:0]           tgt_wdata
);
  phc_pkg::phc_mst_state_t ms;
  phc_pkg::phc_tgt_state_t ts;
  logic [LEN_W-1:0]        left;
  logic [3:0]              cmd;
  logic [1:0]              dec_cnt;
  logic                    frame_prev;
  logic                    expired;
  logic                    xfer;
  logic                    bus_idle;
  logic                    m_done;
  logic                    t_done;
  logic                    m_abort;
  logic                    m_load;
  logic                    addr_phase;
  logic                    hit;

  // Bus events seen at this edge
  assign xfer       = !bus.irdy_n && !bus.trdy_n;
  assign bus_idle   = bus.frame_n && bus.irdy_n;
  assign m_done     = !bus.irdy_n && (!bus.trdy_n || !bus.stop_n) && bus.d_frame_n;
  assign t_done     = !bus.irdy_n && (!bus.d_trdy_n || !bus.d_stop_n) && bus.frame_n;
  assign m_abort    = (ms == phc_pkg::M_DATA) && expired;
  assign m_load     = mst_ready && ((ms == phc_pkg::M_ADDR) || ((ms == phc_pkg::M_DATA)
                      && bus.d_irdy_n && !m_abort && bus.stop_n));
  assign addr_phase = !bus.frame_n && frame_prev && !bus.d_mst_oe && bus.rst_n
                      && (ts == phc_pkg::T_IDLE);
  assign hit        = (phc_pkg::cmd_is_cfg(bus.cbe_n) && bus.idsel)
                      || (phc_pkg::cmd_is_mem(bus.cbe_n) && ((bus.ad & BAR_MASK) == BAR_BASE));

  // Master timeout watcher
  phc_devsel_timer u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (ms == phc_pkg::M_ADDR),
    .seen     (!bus.devsel_n),
    .expired  (expired)
  );

  // Previous FRAME level, marks the address phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_prev <= 1'b1;
    end else begin
      frame_prev <= bus.frame_n;
    end
  end

  // Master sequencing: request, address, data phases, release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ms            <= phc_pkg::M_IDLE;
      bus.d_req_n   <= 1'b1;
      bus.d_req_oe  <= 1'b0;
      bus.d_frame_n <= 1'b1;
      bus.d_irdy_n  <= 1'b1;
      bus.d_mst_oe  <= 1'b0;
      bus.d_cbe_n   <= phc_pkg::CBE_IDLE_N;
      bus.d_ad      <= phc_pkg::AD_ZERO;
      bus.d_ad_oe   <= 1'b0;
      cmd           <= phc_pkg::CBE_IDLE_N;
      left          <= '0;
      mst_busy      <= 1'b0;
      mst_take      <= 1'b0;
      mst_done      <= 1'b0;
      mst_abort     <= 1'b0;
      mst_stopped   <= 1'b0;
    end else if (!bus.rst_n) begin
      ms            <= phc_pkg::M_IDLE;
      bus.d_req_n   <= 1'b1;
      bus.d_req_oe  <= 1'b0;
      bus.d_mst_oe  <= 1'b0;
      bus.d_ad_oe   <= 1'b0;
      mst_busy      <= 1'b0;
      mst_take      <= 1'b0;
    end else begin
      mst_take    <= m_load;
      mst_done    <= 1'b0;
      mst_abort   <= 1'b0;
      mst_stopped <= 1'b0;
      if (m_load) begin
        bus.d_irdy_n  <= 1'b0;
        bus.d_frame_n <= (left == LEN_W'(1));
        bus.d_ad      <= mst_wdata;
      end
      case (ms)
        phc_pkg::M_IDLE: begin
          if (mst_start) begin
            ms           <= phc_pkg::M_REQ;
            bus.d_req_n  <= 1'b0;
            bus.d_req_oe <= 1'b1;
            bus.d_ad     <= mst_addr;
            cmd          <= mst_cmd;
            left         <= (mst_len == '0) ? LEN_W'(1) : mst_len;
            mst_busy     <= 1'b1;
          end
        end
        phc_pkg::M_REQ: begin
          if (!bus.gnt_n && bus_idle) begin
            ms            <= phc_pkg::M_ADDR;
            bus.d_req_n   <= 1'b1;
            bus.d_frame_n <= 1'b0;
            bus.d_mst_oe  <= 1'b1;
            bus.d_cbe_n   <= cmd;
            bus.d_ad_oe   <= 1'b1;
          end
        end
        phc_pkg::M_ADDR: begin
          ms          <= phc_pkg::M_DATA;
          bus.d_cbe_n <= phc_pkg::BE_ALL_N;
          bus.d_ad_oe <= phc_pkg::cmd_is_write(cmd);
        end
        phc_pkg::M_DATA: begin
          if (xfer) begin
            left <= left - 1'b1;
          end
          if (m_abort) begin
            ms            <= phc_pkg::M_TURN;
            bus.d_frame_n <= 1'b1;
            bus.d_irdy_n  <= 1'b1;
            bus.d_ad_oe   <= 1'b0;
            mst_abort     <= 1'b1;
          end else if (m_done) begin
            ms            <= phc_pkg::M_TURN;
            bus.d_irdy_n  <= 1'b1;
            bus.d_ad_oe   <= 1'b0;
            mst_stopped   <= !bus.stop_n;
          end else if (!bus.stop_n) begin
            bus.d_frame_n <= 1'b1;
            bus.d_irdy_n  <= 1'b0;
            if (bus.d_irdy_n) begin
              bus.d_ad <= mst_wdata;
            end
          end else if (xfer) begin
            bus.d_irdy_n <= 1'b1;
          end
        end
        phc_pkg::M_TURN: begin
          ms           <= phc_pkg::M_IDLE;
          bus.d_mst_oe <= 1'b0;
          bus.d_req_oe <= 1'b0;
          bus.d_cbe_n  <= phc_pkg::CBE_IDLE_N;
          mst_busy     <= 1'b0;
          mst_done     <= 1'b1;
        end
        default: ms <= phc_pkg::M_IDLE;
      endcase
    end
  end

  // Master data capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mst_xfer  <= 1'b0;
      mst_rdata <= phc_pkg::AD_ZERO;
    end else begin
      mst_xfer <= (ms == phc_pkg::M_DATA) && xfer;
      if ((ms == phc_pkg::M_DATA) && xfer && !phc_pkg::cmd_is_write(cmd)) begin
        mst_rdata <= bus.ad;
      end
    end
  end

  // Target sequencing: decode, data phases, turnaround
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ts             <= phc_pkg::T_IDLE;
      dec_cnt        <= '0;
      bus.d_trdy_n   <= 1'b1;
      bus.d_stop_n   <= 1'b1;
      bus.d_devsel_n <= 1'b1;
      bus.d_tgt_oe   <= 1'b0;
      bus.d_tad      <= phc_pkg::AD_ZERO;
      bus.d_tad_oe   <= 1'b0;
      tgt_sel        <= 1'b0;
      tgt_cfg        <= 1'b0;
      tgt_write      <= 1'b0;
      tgt_addr       <= phc_pkg::AD_ZERO;
      tgt_take       <= 1'b0;
    end else begin
      tgt_take <= 1'b0;
      case (ts)
        phc_pkg::T_IDLE: begin
          if (addr_phase && hit) begin
            ts        <= phc_pkg::T_DEC;
            dec_cnt   <= 2'h1;
            tgt_sel   <= 1'b1;
            tgt_cfg   <= phc_pkg::cmd_is_cfg(bus.cbe_n);
            tgt_write <= phc_pkg::cmd_is_write(bus.cbe_n);
            tgt_addr  <= bus.ad;
          end
        end
        phc_pkg::T_DEC: begin
          if (dec_cnt == 2'(phc_pkg::DECODE_CLKS - 1)) begin
            ts             <= phc_pkg::T_DATA;
            bus.d_devsel_n <= 1'b0;
            bus.d_tgt_oe   <= 1'b1;
            bus.d_tad_oe   <= !tgt_write;
          end else begin
            dec_cnt <= dec_cnt + 1'b1;
          end
        end
        phc_pkg::T_DATA: begin
          if (xfer) begin
            tgt_addr <= tgt_addr + phc_pkg::ADDR_STEP;
          end
          if (t_done || bus_idle) begin
            ts             <= phc_pkg::T_TURN;
            bus.d_trdy_n   <= 1'b1;
            bus.d_stop_n   <= 1'b1;
            bus.d_devsel_n <= 1'b1;
            bus.d_tad_oe   <= 1'b0;
            tgt_sel        <= 1'b0;
          end else if (tgt_stop && bus.d_stop_n) begin
            bus.d_stop_n <= 1'b0;
            bus.d_trdy_n <= 1'b1;
          end else if (xfer) begin
            bus.d_trdy_n <= 1'b1;
          end else if (bus.d_trdy_n && bus.d_stop_n && tgt_ready) begin
            bus.d_trdy_n <= 1'b0;
            bus.d_tad    <= tgt_rdata;
            tgt_take     <= 1'b1;
          end
        end
        phc_pkg::T_TURN: begin
          ts           <= phc_pkg::T_IDLE;
          bus.d_tgt_oe <= 1'b0;
        end
        default: ts <= phc_pkg::T_IDLE;
      endcase
    end
  end

  // Target data capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tgt_xfer  <= 1'b0;
      tgt_wdata <= phc_pkg::AD_ZERO;
    end else begin
      tgt_xfer <= (ts == phc_pkg::T_DATA) && xfer;
      if ((ts == phc_pkg::T_DATA) && xfer && tgt_write) begin
        tgt_wdata <= bus.ad;
      end
    end
  end
endmodule

// ### design/phc_devsel_timer.sv
`timescale 1ns/1ns
module phc_devsel_timer #(
  parameter int LIMIT = phc_pkg::DEVSEL_TIMEOUT_CLKS,
  parameter int W     = 3
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Watch control
  input  wire logic start,
  input  wire logic seen,
  output logic      expired
);
  logic [W-1:0] cnt;
  logic         run;

  // Counts edges after the address phase until DEVSEL or the limit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt     <= '0;
      run     <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      cnt     <= '0;
      run     <= 1'b1;
      expired <= 1'b0;
    end else if (run) begin
      if (seen) begin
        run <= 1'b0;
      end else if (cnt == W'(LIMIT - 1)) begin
        expired <= 1'b1;
        run     <= 1'b0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

// ### design/phc_host.sv
`timescale 1ns/1ns
module phc_host #(
  parameter int RST_CLKS = phc_pkg::RST_MIN_CLKS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Bus end
  phc_bus_if.host          bus,
  // Host access request
  input  wire logic        h_start,
  input  wire logic [31:0] h_addr,
  input  wire logic [3:0]  h_cmd,
  input  wire logic [31:0] h_wdata,
  output logic             h_busy,
  output logic             h_done,
  output logic             h_abort,
  output logic             h_stopped,
  output logic [31:0]      h_rdata,
  // Memory target for device DMA
  input  wire logic        h_tgt_en,
  input  wire logic        h_tgt_stop,
  input  wire logic [31:0] h_tgt_rdata,
  output logic             h_tgt_xfer,
  output logic [31:0]      h_tgt_wdata
);
  phc_pkg::phc_mst_state_t hs;
  phc_pkg::phc_tgt_state_t ts;
  logic [7:0]              rst_cnt;
  logic [3:0]              cmd;
  logic                    pend;
  logic                    frame_prev;
  logic                    t_write;
  logic                    expired;
  logic                    xfer;

  assign xfer = !bus.irdy_n && !bus.trdy_n;

  phc_devsel_timer u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (hs == phc_pkg::M_ADDR),
    .seen     (!bus.devsel_n),
    .expired  (expired)
  );

  // PCI reset stretch and arbitration
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt   <= '0;
      bus.rst_n <= 1'b0;
      bus.gnt_n <= 1'b1;
      frame_prev <= 1'b1;
    end else begin
      frame_prev <= bus.frame_n;
      if (rst_cnt != 8'(RST_CLKS)) begin
        rst_cnt <= rst_cnt + 1'b1;
      end
      bus.rst_n <= (rst_cnt == 8'(RST_CLKS));
      bus.gnt_n <= !(!bus.req_n && bus.rst_n && !pend && (hs == phc_pkg::M_IDLE));
    end
  end

  // Host master: single data phase access
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hs            <= phc_pkg::M_IDLE;
      pend          <= 1'b0;
      cmd           <= phc_pkg::CBE_IDLE_N;
      bus.h_frame_n <= 1'b1;
      bus.h_irdy_n  <= 1'b1;
      bus.h_mst_oe  <= 1'b0;
      bus.h_cbe_n   <= phc_pkg::CBE_IDLE_N;
      bus.h_ad      <= phc_pkg::AD_ZERO;
      bus.h_ad_oe   <= 1'b0;
      bus.idsel     <= 1'b0;
      h_busy        <= 1'b0;
      h_done        <= 1'b0;
      h_abort       <= 1'b0;
      h_stopped     <= 1'b0;
      h_rdata       <= phc_pkg::AD_ZERO;
    end else begin
      h_done    <= 1'b0;
      h_abort   <= 1'b0;
      h_stopped <= 1'b0;
      case (hs)
        phc_pkg::M_IDLE: begin
          if (h_start && !pend) begin
            pend     <= 1'b1;
            cmd      <= h_cmd;
            bus.h_ad <= h_addr;
            h_busy   <= 1'b1;
          end else if (pend && bus.gnt_n && bus.frame_n && bus.irdy_n && bus.rst_n) begin
            hs            <= phc_pkg::M_ADDR;
            bus.h_frame_n <= 1'b0;
            bus.h_mst_oe  <= 1'b1;
            bus.h_cbe_n   <= cmd;
            bus.h_ad_oe   <= 1'b1;
            bus.idsel     <= phc_pkg::cmd_is_cfg(cmd);
          end
        end
        phc_pkg::M_ADDR: begin
          hs            <= phc_pkg::M_DATA;
          bus.h_frame_n <= 1'b1;
          bus.h_irdy_n  <= 1'b0;
          bus.h_cbe_n   <= phc_pkg::BE_ALL_N;
          bus.h_ad      <= h_wdata;
          bus.h_ad_oe   <= phc_pkg::cmd_is_write(cmd);
          bus.idsel     <= 1'b0;
        end
        phc_pkg::M_DATA: begin
          if (expired) begin
            hs           <= phc_pkg::M_TURN;
            bus.h_irdy_n <= 1'b1;
            bus.h_ad_oe  <= 1'b0;
            h_abort      <= 1'b1;
          end else if (!bus.irdy_n && (!bus.trdy_n || !bus.stop_n)) begin
            hs           <= phc_pkg::M_TURN;
            bus.h_irdy_n <= 1'b1;
            bus.h_ad_oe  <= 1'b0;
            h_stopped    <= bus.trdy_n;
            h_rdata      <= bus.ad;
          end
        end
        phc_pkg::M_TURN: begin
          hs           <= phc_pkg::M_IDLE;
          bus.h_mst_oe <= 1'b0;
          bus.h_cbe_n  <= phc_pkg::CBE_IDLE_N;
          pend         <= 1'b0;
          h_busy       <= 1'b0;
          h_done       <= 1'b1;
        end
        default: hs <= phc_pkg::M_IDLE;
      endcase
    end
  end

  // Host memory target, fast decode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ts             <= phc_pkg::T_IDLE;
      t_write        <= 1'b0;
      bus.h_trdy_n   <= 1'b1;
      bus.h_stop_n   <= 1'b1;
      bus.h_devsel_n <= 1'b1;
      bus.h_tgt_oe   <= 1'b0;
      bus.h_tad      <= phc_pkg::AD_ZERO;
      bus.h_tad_oe   <= 1'b0;
      h_tgt_xfer     <= 1'b0;
      h_tgt_wdata    <= phc_pkg::AD_ZERO;
    end else begin
      h_tgt_xfer <= (ts == phc_pkg::T_DATA) && xfer;
      bus.h_tad  <= h_tgt_rdata;
      if ((ts == phc_pkg::T_DATA) && xfer && t_write) begin
        h_tgt_wdata <= bus.ad;
      end
      case (ts)
        phc_pkg::T_IDLE: begin
          if (!bus.frame_n && frame_prev && !bus.h_mst_oe && h_tgt_en
              && phc_pkg::cmd_is_mem(bus.cbe_n)) begin
            ts             <= phc_pkg::T_DATA;
            t_write        <= phc_pkg::cmd_is_write(bus.cbe_n);
            bus.h_devsel_n <= 1'b0;
            bus.h_trdy_n   <= h_tgt_stop;
            bus.h_stop_n   <= !h_tgt_stop;
            bus.h_tgt_oe   <= 1'b1;
            bus.h_tad_oe   <= !phc_pkg::cmd_is_write(bus.cbe_n);
          end
        end
        phc_pkg::T_DATA: begin
          if (!bus.irdy_n && (!bus.trdy_n || !bus.stop_n) && bus.frame_n) begin
            ts             <= phc_pkg::T_TURN;
            bus.h_trdy_n   <= 1'b1;
            bus.h_stop_n   <= 1'b1;
            bus.h_devsel_n <= 1'b1;
            bus.h_tad_oe   <= 1'b0;
          end else if (h_tgt_stop) begin
            bus.h_stop_n <= 1'b0;
            bus.h_trdy_n <= 1'b1;
          end
        end
        phc_pkg::T_TURN: begin
          ts           <= phc_pkg::T_IDLE;
          bus.h_tgt_oe <= 1'b0;
        end
        default: ts <= phc_pkg::T_IDLE;
      endcase
    end
  end
endmodule

// ### sim/phc_bus_sva.sv
`timescale 1ns/1ns
module phc_bus_sva (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // Resolved lines
  input wire logic       frame_n,
  input wire logic       irdy_n,
  input wire logic       trdy_n,
  input wire logic       stop_n,
  input wire logic       devsel_n,
  input wire logic [3:0] cbe_n,
  input wire logic       gnt_n,
  input wire logic       idsel,
  input wire logic       rst_n,
  // Party drives
  input wire logic       d_mst_oe,
  input wire logic       d_tgt_oe,
  input wire logic       d_trdy_n,
  input wire logic       d_req_oe,
  input wire logic       h_mst_oe
);
  // One clock domain for all checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_req_float: assert property (!rst_n |-> !d_req_oe)
    else $error("request driven in reset");
  a_gnt_ignored: assert property (!rst_n |-> !d_mst_oe)
    else $error("mastering in reset");
  a_start_idle: assert property ($rose(d_mst_oe) |->
    !$past(gnt_n) && $past(frame_n) && $past(irdy_n) && $past(rst_n))
    else $error("start without idle grant");
  a_devsel_medium: assert property (!frame_n && $past(frame_n) && idsel && h_mst_oe
    && cbe_n[3:1] == phc_pkg::CMD_CFG_HI |-> ##[1:2] !devsel_n && d_tgt_oe)
    else $error("select answer late");
  a_watch_five: assert property (($fell(frame_n) && d_mst_oe) ##1 devsel_n [*4]
    |-> d_mst_oe && !irdy_n)
    else $error("gave up too early");
  a_abort_release: assert property (($fell(frame_n) && d_mst_oe) ##1 devsel_n [*5]
    |-> ##3 !d_mst_oe && frame_n && irdy_n)
    else $error("no abort after timeout");
  a_irdy_wait: assert property (d_mst_oe && !irdy_n && !trdy_n |=> irdy_n)
    else $error("initiator ready kept");
  a_trdy_wait: assert property (
    d_tgt_oe && !d_trdy_n && !irdy_n |=> d_trdy_n || !d_tgt_oe)
    else $error("target ready kept");
  a_frame_last: assert property (d_mst_oe && frame_n && !irdy_n |=> frame_n)
    else $error("frame back after last");
  a_stop_ends: assert property (d_mst_oe && !stop_n && !frame_n |-> ##[0:3] frame_n)
    else $error("stop ignored");

  // Length of the current PCI reset pulse, cleared once it ends
  logic [7:0] rst_low;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_low <= 8'h00;
    end else if (rst_n) begin
      rst_low <= 8'h00;
    end else if (rst_low != 8'hFF) begin
      rst_low <= rst_low + 8'h01;
    end
  end
  a_reset_hold: assert property ($rose(rst_n) |-> rst_low >= 8'(phc_pkg::RST_MIN_CLKS))
    else $error("reset pulse too short");
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        core_clk, nrst, mst_start, mst_ready, tgt_ready, tgt_stop, h_start, h_tgt_en;
  logic        h_tgt_stop, mst_busy, mst_take, mst_xfer, mst_done, mst_abort, mst_stopped;
  logic        tgt_sel, tgt_cfg, tgt_write, tgt_take, tgt_xfer, h_busy, h_done, h_abort;
  logic        h_stopped, h_tgt_xfer, ab, st;
  logic [3:0]  mst_cmd, h_cmd;
  logic [7:0]  mst_len;
  logic [31:0] mst_addr, mst_wdata, mst_rdata, tgt_rdata, tgt_addr, tgt_wdata;
  logic [31:0] h_addr, h_wdata, h_rdata, h_tgt_rdata, h_tgt_wdata;
  logic [31:0] exp_q[$];
  logic [3:0]  hcmds[5] = '{4'hB, 4'hA, 4'h7, 4'h6, 4'h2};
  int          mismatches = 0;
  int          checks_done = 0;

  phc_bus_if bus ();
  phc_device phc_device_inst (.core_clk, .nrst, .bus(bus.dev), .mst_start, .mst_addr,
    .mst_cmd, .mst_len, .mst_ready, .mst_wdata, .mst_busy, .mst_take, .mst_xfer, .mst_rdata,
    .mst_done, .mst_abort, .mst_stopped, .tgt_ready, .tgt_stop, .tgt_rdata, .tgt_sel,
    .tgt_cfg, .tgt_write, .tgt_addr, .tgt_take, .tgt_xfer, .tgt_wdata);
  phc_host phc_host_inst (.core_clk, .nrst, .bus(bus.host), .h_start, .h_addr, .h_cmd,
    .h_wdata, .h_busy, .h_done, .h_abort, .h_stopped, .h_rdata, .h_tgt_en, .h_tgt_stop,
    .h_tgt_rdata, .h_tgt_xfer, .h_tgt_wdata);
  phc_bus_sva phc_bus_sva_inst (.core_clk, .nrst, .frame_n(bus.frame_n),
    .irdy_n(bus.irdy_n), .trdy_n(bus.trdy_n), .stop_n(bus.stop_n), .devsel_n(bus.devsel_n),
    .cbe_n(bus.cbe_n), .gnt_n(bus.gnt_n), .idsel(bus.idsel), .rst_n(bus.rst_n),
    .d_mst_oe(bus.d_mst_oe), .d_tgt_oe(bus.d_tgt_oe), .d_trdy_n(bus.d_trdy_n),
    .d_req_oe(bus.d_req_oe), .h_mst_oe(bus.h_mst_oe));

  // Clock of 100 ns period
  always #50 core_clk = ~core_clk;

  task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input logic got, input logic exp);
    chkw({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Reference model: every moved word except device target reads against the queue or held source
  always @(posedge core_clk) begin
    if (h_tgt_xfer && mst_cmd[0]) begin
      chkw(h_tgt_wdata, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
    if (mst_xfer && !mst_cmd[0]) begin
      chkw(mst_rdata, h_tgt_rdata);
    end
    if (tgt_xfer && tgt_write) begin
      chkw(tgt_wdata, h_wdata);
      chkw(tgt_addr, h_addr + phc_pkg::ADDR_STEP);
      chkf(tgt_cfg, h_cmd[3]);
    end
  end

  // Next write word once the current one is on the bus
  always @(negedge core_clk) begin
    if (mst_take) begin
      mst_wdata = $urandom;
      exp_q.push_back(mst_wdata);
    end
  end

  // Device master access and its outcome flags
  task automatic dm(input logic [3:0] cmd, input int n, input logic eab, input logic est);
    int i;
    @(negedge core_clk);
    exp_q = {mst_wdata};
    h_tgt_rdata = $urandom;
    mst_cmd = cmd;
    mst_len = n[7:0];
    mst_addr = 32'h0001_0000 | ($urandom & 32'h0000_fffc);
    mst_start = 1'b1;
    @(negedge core_clk);
    mst_start = 1'b0;
    ab = 1'b0;
    st = 1'b0;
    for (i = 0; i < 300 && mst_done !== 1'b1; i++) begin
      @(negedge core_clk);
      ab = ab | mst_abort;
      st = st | mst_stopped;
    end
    chkf(mst_done, 1'b1);
    chkf(mst_busy, 1'b0);
    chkf(ab, eab);
    chkf(st, est);
  endtask

  // Host access to the device target
  task automatic ha(input logic [3:0] cmd, input logic eab, input logic est);
    int i;
    @(negedge core_clk);
    h_cmd = cmd;
    h_addr = $urandom & 32'h0000_0ffc;
    h_wdata = $urandom;
    tgt_rdata = $urandom;
    h_start = 1'b1;
    @(negedge core_clk);
    h_start = 1'b0;
    ab = 1'b0;
    st = 1'b0;
    for (i = 0; i < 300 && h_done !== 1'b1; i++) begin
      @(negedge core_clk);
      ab = ab | h_abort;
      st = st | h_stopped;
    end
    chkf(h_done, 1'b1);
    chkf(ab, eab);
    chkf(st, est);
    if (!cmd[0] && !eab && !est) begin
      chkw(h_rdata, tgt_rdata);
    end
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h0ced_d076));
    core_clk = 0;
    nrst = 0;
    {mst_start, h_start, tgt_stop, h_tgt_stop} = 4'h0;
    {mst_ready, tgt_ready, h_tgt_en} = 3'h7;
    {mst_cmd, h_cmd, mst_len} = 16'h0000;
    {mst_addr, mst_wdata, tgt_rdata} = {3{32'h0000_0000}};
    {h_addr, h_wdata, h_tgt_rdata} = {3{32'h0000_0000}};
    repeat (20) @(negedge core_clk);
    nrst = 1;
    // Master requests are only taken once the PCI reset has ended
    wait (bus.rst_n === 1'b1);
    dm(4'h7, 3, 1'b0, 1'b0);
    dm(4'h6, 2, 1'b0, 1'b0);
    h_tgt_en = 1'b0;
    dm(4'h7, 1, 1'b1, 1'b0);
    h_tgt_en = 1'b1;
    h_tgt_stop = 1'b1;
    dm(4'h7, 3, 1'b0, 1'b1);
    h_tgt_stop = 1'b0;
    for (int k = 0; k < 5; k++) begin
      ha(hcmds[k], hcmds[k] == 4'h2, 1'b0);
    end
    tgt_stop = 1'b1;
    ha(4'hA, 1'b0, 1'b1);
    tgt_stop = 1'b0;
    stop_test();
  end

  // Watchdog
  initial begin
    #(100 * 20000);
    mismatches++;
    stop_test();
  end
endmodule
